// [pao_quad.sv]
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
// Purpose: Quad end: autonomy policy, emergency shutdown, register map
// Assumes: detect/class results and faults arrive as per-port pulses
// Notes:   Event registers clear on read
module pao_quad
  import pao_pkg::*;
#(
  parameter int          NPORT    = 4,
  parameter logic [6:0]  QUAD_ADDR = 7'h20
)(
  input  wire logic             clk,          // Clock
  input  wire logic             sys_rst,      // Sync reset
  pao_if.quad                   lnk,          // Link to host
  input  wire logic [2:0]       auto_strap,   // Strap level code
  input  wire logic [NPORT-1:0] det_ok,       // Detection passed pulse
  input  wire logic [NPORT-1:0] cls_ok,       // Classification done pulse
  input  wire logic [NPORT-1:0] port_fault,   // Any port fault pulse
  input  wire logic [NPORT-1:0] pgood,        // Supply good level
  output logic      [NPORT-1:0] port_on,      // Power switch enable
  output logic      [NPORT-1:0] probe_run     // Detect/class active
);
  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] mask_q, mode_q, probe_q, prio_q, cfg_q, map_q, budget_q;
  logic [7:0] lvl_lo_q, lvl_hi_q, pwr_evt_q, cd_evt_q, rail_q, rdata_q;
  logic       strap_q, emerg_q, pin_d1_q, rst_d1_q;
  logic [NPORT-1:0] on_q, pg_d1_q;

  wire sel   = (lnk.bus_addr == QUAD_ADDR);
  wire wr_en = sel & lnk.wr;
  wire rd_en = sel & lnk.rd;
  wire strap_auto = (auto_strap != PAO_STRAP_NONE);

  // ************************************************************
  // Serial code receiver
  // ************************************************************
  // Nominal bit timing; mid-bit sampling absorbs 24 to 26 us bits
  typedef enum logic [1:0] {PAO_R_IDLE, PAO_R_START, PAO_R_BITS} pao_rx_type;
  pao_rx_type rx_q;
  logic [15:0] rcnt_q;
  logic [1:0]  rbit_q;
  logic [2:0]  code_q;
  logic        code_ok_q;
  wire  pin_rise = lnk.emergency_off_input & ~pin_d1_q;
  wire  mid      = (rcnt_q == 16'(PAO_HALF_CYC - 1));
  wire  full     = (rcnt_q == 16'(PAO_BIT_CYC - 1));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_q    <= PAO_R_IDLE;
      rcnt_q  <= 16'h0000;
      rbit_q  <= 2'h0;
      code_q    <= 3'h0;
      code_ok_q <= 1'b0;
    end else begin
      // One-cycle strobe once the last code bit is in
      code_ok_q <= 1'b0;
      case (rx_q)
        PAO_R_IDLE: begin
          // Start bit is a rising edge, only in graded mode
          rcnt_q <= 16'h0000;
          if (pin_rise & cfg_q[PAO_CFG_GRADED]) rx_q <= PAO_R_START;
        end
        PAO_R_START: begin
          // Skip the whole start bit before counting code bits
          rcnt_q <= full ? 16'h0000 : rcnt_q + 16'h0001;
          if (full) begin
            rx_q   <= PAO_R_BITS;
            rbit_q <= 2'h0;
          end
        end
        PAO_R_BITS: begin
          rcnt_q <= full ? 16'h0000 : rcnt_q + 16'h0001;
          if (mid) code_q <= {code_q[1:0], lnk.emergency_off_input};
          if (full) begin
            rbit_q <= rbit_q + 2'h1;
            if (rbit_q == 2'(PAO_CODE_BITS - 1)) begin
              rx_q      <= PAO_R_IDLE;
              code_ok_q <= 1'b1;
            end
          end
        end
        default: rx_q <= PAO_R_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Shutdown selection
  // ************************************************************
  logic [NPORT-1:0] kill;
  logic [NPORT-1:0] auto_port;
  wire  edge_hit = pin_rise & ~cfg_q[PAO_CFG_GRADED];
  // Two mode bits per port, both set means automatic
  generate
    for (genvar i = 0; i < NPORT; i++) begin : g_port
      wire [2:0] lvl = (i < 2) ? lvl_lo_q[3*(i%2)+:3] : lvl_hi_q[3*(i%2)+:3];
      assign kill[i] = on_q[i] & ((edge_hit & prio_q[i])
                     | (code_ok_q & (lvl >= code_q)));
      assign auto_port[i] = mode_q[2*i] & mode_q[2*i+1]
                          & probe_q[i] & probe_q[i+PAO_GRADE_OFS];
      assign probe_run[i] = auto_port[i] & ~on_q[i];
    end
  endgenerate
  // Force-off clears the same records as a shutdown
  wire [NPORT-1:0] force_off = wr_en && lnk.reg_addr == PAO_REG_FORCE ?
                               lnk.wdata[NPORT-1:0] : '0;
  wire [NPORT-1:0] drop  = kill | force_off | port_fault;
  wire [NPORT-1:0] start = auto_port & det_ok & cls_ok;

  always_ff @(posedge clk) begin
    if (sys_rst) on_q <= '0;
    else         on_q <= (on_q | start) & ~drop;
  end
  assign port_on = on_q;

  // ************************************************************
  // Register file
  // ************************************************************
  wire rd_pwr = rd_en && lnk.reg_addr == PAO_REG_PWR_EVT;
  wire rd_cd  = rd_en && lnk.reg_addr == PAO_REG_CD_EVT;
  wire rd_rl  = rd_en && lnk.reg_addr == PAO_REG_RAIL;
  wire [NPORT-1:0] pg_chg = pgood ^ pg_d1_q;
  wire [NPORT-1:0] en_chg = on_q ^ ((on_q | start) & ~drop);
  wire [NPORT-1:0] clr_p  = kill | force_off;
  wire [7:0] intr = {|rail_q, 2'b00, |cd_evt_q[7:4], |cd_evt_q[3:0],
                     1'b0, |pwr_evt_q[7:4], |pwr_evt_q[3:0]};
  // Strap codes 1 to 4 midspan, 5 to 7 endspan
  logic [7:0] strap_budget;
  always_comb begin
    case (auto_strap)
      3'h1, 3'h5: strap_budget = PAO_BUDGET_A;
      3'h2, 3'h6: strap_budget = PAO_BUDGET_B;
      3'h3, 3'h7: strap_budget = PAO_BUDGET_C;
      3'h4:       strap_budget = PAO_BUDGET_D;
      default:    strap_budget = PAO_BUDGET_D;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      {mask_q, mode_q, probe_q, prio_q, cfg_q} <= '0;
      {map_q, budget_q, lvl_lo_q, lvl_hi_q} <= '0;
      {pwr_evt_q, cd_evt_q, rail_q, rdata_q} <= '0;
      {strap_q, emerg_q, pin_d1_q} <= '0;
      rst_d1_q <= 1'b1;
      pg_d1_q  <= '0;
    end else begin
      rst_d1_q <= 1'b0;
      pin_d1_q <= lnk.emergency_off_input;
      pg_d1_q  <= pgood;
      // Strap image loads on the first cycle after reset
      if (rst_d1_q) begin
        strap_q <= strap_auto;
        if (strap_auto) begin
          map_q    <= PAO_AUTO_MAP;
          mask_q   <= PAO_AUTO_MASK;
          mode_q   <= PAO_ALL_ON;
          probe_q  <= PAO_ALL_ON;
          budget_q <= strap_budget;
          cfg_q[PAO_CFG_MIDSPAN] <= (auto_strap < PAO_STRAP_ENDSPAN);
        end
      end else if (wr_en) begin
        case (lnk.reg_addr)
          PAO_REG_INT_MASK: mask_q   <= lnk.wdata;
          PAO_REG_MODE:     mode_q   <= lnk.wdata;
          PAO_REG_PROBE:    probe_q  <= lnk.wdata;
          PAO_REG_PRIO:     prio_q   <= lnk.wdata;
          PAO_REG_GENCFG:   cfg_q    <= lnk.wdata;
          PAO_REG_MAP:      map_q    <= lnk.wdata;
          PAO_REG_BUDGET:   budget_q <= lnk.wdata;
          PAO_REG_LEVEL_LO: lvl_lo_q <= lnk.wdata;
          PAO_REG_LEVEL_HI: lvl_hi_q <= lnk.wdata;
          default: ;
        endcase
      end
      // Set wins over clear-on-read
      pwr_evt_q <= ((rd_pwr ? PAO_ZERO : pwr_evt_q)
                   | {4'(pg_chg), 4'(en_chg)});
      cd_evt_q  <= ((rd_cd ? PAO_ZERO : cd_evt_q)
                   & ~{4'(clr_p), 4'(clr_p)})
                   | {4'(cls_ok), 4'(det_ok)};
      rail_q    <= (rd_rl ? PAO_ZERO : rail_q)
                   | {7'h00, |kill};
      emerg_q   <= |kill;
      case (lnk.reg_addr)
        PAO_REG_INT:      rdata_q <= intr;
        PAO_REG_INT_MASK: rdata_q <= mask_q;
        PAO_REG_PWR_EVT:  rdata_q <= pwr_evt_q;
        PAO_REG_CD_EVT:   rdata_q <= cd_evt_q;
        PAO_REG_RAIL:     rdata_q <= rail_q;
        PAO_REG_MODE:     rdata_q <= mode_q;
        PAO_REG_PROBE:    rdata_q <= probe_q;
        PAO_REG_PRIO:     rdata_q <= prio_q;
        PAO_REG_GENCFG:   rdata_q <= cfg_q;
        PAO_REG_MAP:      rdata_q <= map_q;
        PAO_REG_BUDGET:   rdata_q <= budget_q;
        PAO_REG_LEVEL_LO: rdata_q <= lvl_lo_q;
        PAO_REG_LEVEL_HI: rdata_q <= lvl_hi_q;
        PAO_REG_STATUS:   rdata_q <= {2'b00, emerg_q, strap_q, 4'(on_q)};
        default:          rdata_q <= PAO_ZERO;
      endcase
    end
  end
  assign lnk.rdata     = rdata_q;
  assign lnk.irq_out_n = ~|(intr & mask_q);
endmodule // pao_quad

// [pao_pkg.sv]
// Purpose: Shared constants for port autonomy and emergency shutdown
// Assumes: 40 MHz clock, one quad of four ports per register map
// Notes:   One rule per line below
// Operation
// - Auto mode powers port after detect/classify
// - Strap sampled at reset selects power budget
// - Strap fixes location flag, config bit 0
// - Strap mode implies identity map, enables E4
// - Strap mode implies all auto, all probing
// - Host may make one port autonomous anytime
// - Host writes full autonomy set per quad
// - Config select bit chooses shutdown scheme
// - Only low-priority flagged ports are affected
// - Rising edge kills low-priority ports within 50us
// - Shutdown records change events and emergency bit
// - Shutdown clears same bits as force-off
// - Three-bit level, 000 highest, 111 lowest
// - Serial code bit period 24 to 26 us
// - Shut ports with level at or above code
// - Selected ports off within 50us of code
// - Host idles input 125us between codes
// - Each quad answers at its own address
// - Emergency off clears per-port event records
// - Interrupt low when summary and enable set
package pao_pkg;
  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] PAO_REG_INT      = 8'h00;
  localparam logic [7:0] PAO_REG_INT_MASK = 8'h01;
  localparam logic [7:0] PAO_REG_PWR_EVT  = 8'h03;
  localparam logic [7:0] PAO_REG_CD_EVT   = 8'h05;
  localparam logic [7:0] PAO_REG_RAIL     = 8'h0B;
  localparam logic [7:0] PAO_REG_MODE     = 8'h12;
  localparam logic [7:0] PAO_REG_PROBE    = 8'h13;
  localparam logic [7:0] PAO_REG_FORCE    = 8'h19;
  localparam logic [7:0] PAO_REG_PRIO     = 8'h15;
  localparam logic [7:0] PAO_REG_GENCFG   = 8'h17;
  localparam logic [7:0] PAO_REG_MAP      = 8'h26;
  localparam logic [7:0] PAO_REG_BUDGET   = 8'h29;
  localparam logic [7:0] PAO_REG_LEVEL_LO = 8'h2A;
  localparam logic [7:0] PAO_REG_LEVEL_HI = 8'h2B;
  localparam logic [7:0] PAO_REG_STATUS   = 8'h10;
  // ************************************************************
  // Fields and strap values
  // ************************************************************
  localparam int         PAO_CFG_MIDSPAN  = 0;
  localparam int         PAO_CFG_GRADED   = 1;
  localparam int         PAO_RAIL_EOFF    = 0;
  localparam int         PAO_INT_PEN      = 0;
  localparam int         PAO_INT_PGOOD    = 1;
  localparam int         PAO_INT_DETECT   = 3;
  localparam int         PAO_INT_CLASS    = 4;
  localparam int         PAO_INT_SUPPLY   = 7;
  localparam logic [7:0] PAO_AUTO_MAP     = 8'hE4;
  localparam logic [7:0] PAO_AUTO_MASK    = 8'hE4;
  localparam logic [7:0] PAO_ALL_ON       = 8'hFF;
  localparam logic [7:0] PAO_ZERO         = 8'h00;
  localparam logic [2:0] PAO_STRAP_NONE   = 3'h0;
  localparam logic [7:0] PAO_BUDGET_A     = 8'h11;
  localparam logic [7:0] PAO_BUDGET_B     = 8'h22;
  localparam logic [7:0] PAO_BUDGET_C     = 8'h00;
  localparam logic [7:0] PAO_BUDGET_D     = 8'h33;
  localparam int         PAO_CODE_BITS    = 3;
  localparam int         PAO_GRADE_OFS    = 4;
  localparam logic [2:0] PAO_STRAP_ENDSPAN = 3'h5;
  // ************************************************************
  // Timing
  // ************************************************************
  localparam int PAO_CLK_KHZ      = 40000;
  localparam int PAO_BIT_NOM_US   = 25;
  localparam int PAO_OFF_MAX_US   = 50;
  localparam int PAO_GAP_MIN_US   = 125;
  localparam int PAO_BIT_CYC      = PAO_BIT_NOM_US * PAO_CLK_KHZ / 1000;
  localparam int PAO_HALF_CYC     = PAO_BIT_CYC / 2;
  localparam int PAO_GAP_CYC      = (PAO_GAP_MIN_US * PAO_CLK_KHZ + 999) / 1000;
  localparam int PAO_DET_CYC      = 16;
endpackage

// [pao_if.sv]
`timescale 1ns/10ps
// Purpose: Link between host and quad: register port and shutdown pin
// Assumes: one clock, synchronous signals
// Notes:   Quad decodes its own bus address
interface pao_if;
  logic [6:0] bus_addr;
  logic [7:0] reg_addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       emergency_off_input;
  logic       irq_out_n;
  modport quad (input bus_addr, reg_addr, wdata, wr, rd, emergency_off_input,
                output rdata, irq_out_n);
  modport host (output bus_addr, reg_addr, wdata, wr, rd, emergency_off_input,
                input rdata, irq_out_n);
endinterface

// [pao_host.sv]
`timescale 1ns/10ps
// Purpose: Host end: passes register accesses, sends shutdown codes
// Assumes: user commands are single-cycle pulses
// Notes:   Enforces bit period and inter-code gap
module pao_host
  import pao_pkg::*;
(
  input  wire logic       clk,        // Clock
  input  wire logic       sys_rst,    // Sync reset
  pao_if.host             lnk,        // Link to quad
  input  wire logic [6:0] u_bus_addr, // Target quad address
  input  wire logic [7:0] u_addr,     // Register offset
  input  wire logic [7:0] u_wdata,    // Write data
  input  wire logic       u_wr,       // Write strobe
  input  wire logic       u_rd,       // Read strobe
  output logic      [7:0] u_rdata,    // Read data
  output logic            u_irq,      // Interrupt pending
  input  wire logic       u_edge,     // One-bit shutdown edge
  input  wire logic       u_send,     // Send graded code
  input  wire logic [2:0] u_code,     // Code to send
  output logic            u_busy      // Pin engine busy
);
  typedef enum logic [1:0] {PAO_H_IDLE, PAO_H_SEND, PAO_H_GAP} pao_hst_type;
  pao_hst_type st_q;
  logic [2:0]  frame_q;
  logic [2:0]  nbit_q;
  logic [15:0] cnt_q;
  logic        pin_q;
  wire         bit_end = (cnt_q == 16'(PAO_BIT_CYC - 1));
  wire         gap_end = (cnt_q == 16'(PAO_GAP_CYC - 1));

  assign lnk.bus_addr = u_bus_addr;
  assign lnk.reg_addr = u_addr;
  assign lnk.wdata    = u_wdata;
  assign lnk.wr       = u_wr;
  assign lnk.rd       = u_rd;
  assign lnk.emergency_off_input = pin_q;
  assign u_rdata      = lnk.rdata;
  assign u_irq        = ~lnk.irq_out_n;
  assign u_busy       = (st_q != PAO_H_IDLE);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q    <= PAO_H_IDLE;
      frame_q <= 3'h0;
      nbit_q  <= 3'h0;
      cnt_q   <= 16'h0000;
      pin_q   <= 1'b0;
    end else begin
      case (st_q)
        PAO_H_IDLE: begin
          cnt_q <= 16'h0000;
          if (u_send) begin
            frame_q <= u_code;
            nbit_q  <= 3'(PAO_CODE_BITS + 1);
            pin_q   <= 1'b1;
            st_q    <= PAO_H_SEND;
          end else if (u_edge) begin
            pin_q <= 1'b1;
            st_q  <= PAO_H_SEND;
            frame_q <= 3'h0;
            nbit_q  <= 3'h1;
          end
        end
        PAO_H_SEND: begin
          cnt_q <= bit_end ? 16'h0000 : cnt_q + 16'h0001;
          if (bit_end) begin
            nbit_q  <= nbit_q - 3'h1;
            frame_q <= {frame_q[1:0], 1'b0};
            pin_q   <= (nbit_q == 3'h1) ? 1'b0 : frame_q[2];
            if (nbit_q == 3'h1) st_q <= PAO_H_GAP;
          end
        end
        PAO_H_GAP: begin
          cnt_q <= cnt_q + 16'h0001;
          if (gap_end) st_q <= PAO_H_IDLE;
        end
        default: st_q <= PAO_H_IDLE;
      endcase
    end
  end
endmodule // pao_host

// [pao_props.sv]
// Purpose: Assertions on the host to quad link
// Assumes: one clock, link signals only
// Notes:   Low pin run counter saturates; high run counter wraps
`timescale 1ns/10ps
module pao_props
  import pao_pkg::*;
#(
  parameter logic [6:0] QUAD_ADDR = 7'h20
)(
  input wire logic       clk,                 // Clock
  input wire logic       sys_rst,             // Sync reset
  input wire logic [6:0] bus_addr,            // Quad address
  input wire logic [7:0] reg_addr,            // Offset
  input wire logic [7:0] wdata,               // Write data
  input wire logic       wr,                  // Write strobe
  input wire logic       rd,                  // Read strobe
  input wire logic [7:0] rdata,               // Read data
  input wire logic       emergency_off_input, // Shutdown pin
  input wire logic       irq_out_n            // Interrupt, low
);
  // ****************
  // Pin run counters
  // ****************
  logic [12:0] hi_q;
  logic [12:0] lo_q;
  wire         ws  = wr && bus_addr == QUAD_ADDR;
  wire         rs  = rd && bus_addr == QUAD_ADDR;
  wire         pin = emergency_off_input;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hi_q <= 13'h0000;
      lo_q <= 13'h1FFF;
    end else begin
      hi_q <= pin ? hi_q + 13'h0001 : 13'h0000;
      lo_q <= pin ? 13'h0000 : lo_q + {12'h000, ~&lo_q};
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_irq_idle_reset: assert property ($fell(sys_rst) |-> irq_out_n)
    else $error("irq low after reset");
  a_pin_idle_reset: assert property ($fell(sys_rst) |-> !pin)
    else $error("pin high after reset");
  a_bit_whole: assert property ($fell(pin) |-> hi_q != 13'h0000 && hi_q % PAO_BIT_CYC == 0)
    else $error("high run not whole bits");
  a_code_length: assert property (hi_q <= 4 * PAO_BIT_CYC)
    else $error("high run too long");
  a_code_gap: assert property ($rose(pin) |-> lo_q >= PAO_GAP_CYC ||
    (lo_q <= 3 * PAO_BIT_CYC && lo_q % PAO_BIT_CYC == 0))
    else $error("bad low run before rise");
  a_unmapped_zero: assert property (rs && reg_addr[7:6] != 2'h0 |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_irq_quiet: assert property ((rs && reg_addr == PAO_REG_INT) ##1 (rdata == 8'h00)
    |-> $past(irq_out_n))
    else $error("irq low with no summary bit");
  a_map_back: assert property ((ws && reg_addr == PAO_REG_MAP) ##1 (rs && reg_addr == PAO_REG_MAP)
    |=> rdata == $past(wdata, 2))
    else $error("map readback wrong");
  a_budget_back: assert property ((ws && reg_addr == PAO_REG_BUDGET) ##1
    (rs && reg_addr == PAO_REG_BUDGET) |=> rdata == $past(wdata, 2))
    else $error("budget readback wrong");
  a_mode_back: assert property ((ws && reg_addr == PAO_REG_MODE) ##1
    (rs && reg_addr == PAO_REG_MODE) |=> rdata == $past(wdata, 2))
    else $error("mode readback wrong");
endmodule // pao_props

// [port_autonomy_and_emergency_shutdown_tb.sv]
// Purpose: Self-checking bench, host and quad back to back
// Assumes: 40 MHz clock, one quad at 0x20
// Notes:   pgood follows port_on
`timescale 1ns/10ps
module port_autonomy_and_emergency_shutdown_tb
  import pao_pkg::*;
;
  localparam logic [6:0] QA = 7'h20;
  logic       clk, sys_rst, u_wr, u_rd, u_edge, u_send, u_irq, u_busy;
  logic [6:0] u_bus_addr;
  logic [7:0] u_addr, u_wdata, u_rdata;
  logic [2:0] u_code, auto_strap;
  logic [3:0] det_ok, cls_ok, port_fault, pgood, port_on, probe_run;
  int         fails, checks_done;
  assign pgood = port_on;
  pao_if lnk_if ();
  pao_host pao_host_inst (.clk(clk), .sys_rst(sys_rst), .lnk(lnk_if),
    .u_bus_addr(u_bus_addr), .u_addr(u_addr), .u_wdata(u_wdata), .u_wr(u_wr),
    .u_rd(u_rd), .u_rdata(u_rdata), .u_irq(u_irq), .u_edge(u_edge),
    .u_send(u_send), .u_code(u_code), .u_busy(u_busy));
  pao_quad #(.NPORT(4), .QUAD_ADDR(QA)) pao_quad_inst (.clk(clk), .sys_rst(sys_rst),
    .lnk(lnk_if), .auto_strap(auto_strap), .det_ok(det_ok), .cls_ok(cls_ok),
    .port_fault(port_fault), .pgood(pgood), .port_on(port_on), .probe_run(probe_run));
  pao_props #(.QUAD_ADDR(QA)) pao_props_inst (.clk(clk), .sys_rst(sys_rst),
    .bus_addr(lnk_if.bus_addr), .reg_addr(lnk_if.reg_addr), .wdata(lnk_if.wdata),
    .wr(lnk_if.wr), .rd(lnk_if.rd), .rdata(lnk_if.rdata),
    .emergency_off_input(lnk_if.emergency_off_input), .irq_out_n(lnk_if.irq_out_n));
  // *************
  // Shared tasks
  // *************
  task automatic results();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    u_addr <= a;
    u_wdata <= d;
    u_wr <= 1'b1;
    @(posedge clk);
    u_wr <= 1'b0;
    #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    u_addr <= a;
    u_rd <= 1'b1;
    @(posedge clk);
    u_rd <= 1'b0;
    #1;
    d = u_rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    chk(d, exp);
  endtask
  task automatic do_reset(input logic [2:0] s);
    auto_strap <= s;
    sys_rst <= 1'b1;
    tick(8);
    sys_rst <= 1'b0;
    tick(2);
  endtask
  task automatic pulse(input logic [3:0] p);
    det_ok <= p;
    cls_ok <= p;
    @(posedge clk);
    det_ok <= 4'h0;
    cls_ok <= 4'h0;
    tick(1);
  endtask
  task automatic wait_on(input logic [3:0] e, input int lim);
    int n = 0;
    while (port_on !== e && n < lim) begin
      tick(1);
      n++;
    end
    chk({4'h0, port_on}, {4'h0, e});
  endtask
  task automatic send(input logic [2:0] c);
    int n = 0;
    while (u_busy !== 1'b0 && n < 9000) begin
      tick(1);
      n++;
    end
    u_code <= c;
    u_send <= 1'b1;
    @(posedge clk);
    u_send <= 1'b0;
    tick(1);
  endtask
  // **********
  // Scenarios
  // **********
  task automatic t_strap();
    logic [7:0] bud [8];
    logic [7:0] on;
    bud = '{8'h00, 8'h11, 8'h22, 8'h00, 8'h33, 8'h11, 8'h22, 8'h00};
    for (int s = 0; s < 8; s++) begin
      do_reset(3'(s));
      on = (s != 0) ? 8'hFF : 8'h00;
      rchk(PAO_REG_BUDGET, bud[s]);
      rchk(PAO_REG_GENCFG, {7'h00, s inside {[1:4]}});
      rchk(PAO_REG_MAP, on & 8'hE4);
      rchk(PAO_REG_INT_MASK, on & 8'hE4);
      rchk(PAO_REG_MODE, on);
      rchk(PAO_REG_PROBE, on);
      rchk(PAO_REG_STATUS, {3'h0, s != 0, 4'h0});
    end
  endtask
  task automatic t_auto();
    chk({port_on, probe_run}, 8'h0F);
    pulse(4'h1);
    chk({port_on, probe_run}, 8'h1E);
    port_fault <= 4'h1;
    @(posedge clk);
    port_fault <= 4'h0;
    tick(1);
    chk({port_on, probe_run}, 8'h0F);
  endtask
  task automatic t_host();
    do_reset(3'h0);
    rchk(PAO_REG_INT, 8'h00);
    u_bus_addr <= 7'h21;
    wr_reg(PAO_REG_MODE, 8'hFF);
    u_bus_addr <= QA;
    rchk(PAO_REG_MODE, 8'h00);
    wr_reg(PAO_REG_MAP, 8'hE4);
    rchk(PAO_REG_MAP, 8'hE4);
    wr_reg(PAO_REG_BUDGET, 8'h33);
    rchk(PAO_REG_BUDGET, 8'h33);
    wr_reg(PAO_REG_MODE, 8'h0C);
    rchk(PAO_REG_MODE, 8'h0C);
    wr_reg(PAO_REG_PROBE, 8'h22);
    chk({port_on, probe_run}, 8'h02);
    pulse(4'h3);
    chk({port_on, probe_run}, 8'h20);
    wr_reg(PAO_REG_FORCE, 8'h02);
    chk({port_on, probe_run}, 8'h02);
    rchk(PAO_REG_CD_EVT, 8'h11);
    rchk(8'h7F, 8'h00);
  endtask
  task automatic t_onebit();
    logic [7:0] d;
    wr_reg(PAO_REG_MODE, 8'hFF);
    wr_reg(PAO_REG_PROBE, 8'hFF);
    pulse(4'hF);
    chk({port_on, probe_run}, 8'hF0);
    wr_reg(PAO_REG_PRIO, 8'h05);
    wr_reg(PAO_REG_INT_MASK, 8'h03);
    rd_reg(PAO_REG_PWR_EVT, d);
    chk({7'h00, u_irq}, 8'h00);
    u_edge <= 1'b1;
    @(posedge clk);
    u_edge <= 1'b0;
    wait_on(4'hA, 2000);
    tick(2);
    chk({7'h00, u_irq}, 8'h01);
    rchk(PAO_REG_INT, 8'h9B);
    rchk(PAO_REG_PWR_EVT, 8'h55);
    rchk(PAO_REG_CD_EVT, 8'hAA);
    rchk(PAO_REG_RAIL, 8'h01);
    rchk(PAO_REG_INT, 8'h00);
    chk({7'h00, u_irq}, 8'h00);
  endtask
  task automatic t_graded();
    wr_reg(PAO_REG_GENCFG, 8'h02);
    wr_reg(PAO_REG_LEVEL_LO, 8'h28);
    wr_reg(PAO_REG_LEVEL_HI, 8'h26);
    rchk(PAO_REG_GENCFG, 8'h02);
    pulse(4'h5);
    chk({4'h0, port_on}, 8'h0F);
    send(3'h5);
    tick(3000);
    chk({4'h0, port_on}, 8'h0F);
    wait_on(4'h9, 3100);
    send(3'h0);
    wait_on(4'h0, 7000);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #2000000;
    fails++;
    results();
  end
  initial begin
    {u_wr, u_rd, u_edge, u_send} = 4'h0;
    {u_bus_addr, u_addr, u_wdata, u_code} = {QA, 8'h00, 8'h00, 3'h0};
    {det_ok, cls_ok, port_fault} = 12'h000;
    t_strap();
    t_auto();
    t_host();
    t_onebit();
    t_graded();
    results();
  end
endmodule // port_autonomy_and_emergency_shutdown_tb
